// ==== sps_flash_model.sv ====
// Behavioural flash macro: ends each erase or write after a delay.
// Assumes the sequencer pulses flash_start for one cycle.
`timescale 1ns/10ps
`default_nettype none
module sps_flash_model
#(
   parameter int DLY = 12
)
(
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        rst_n,
   // Sequencer side
   input wire logic        flash_start,
   output logic            flash_done,
   input wire logic [14:0] flash_rd_addr,
   output logic [15:0]     flash_rd_word
);
   int cnt_reg;
   int cnt_next;

   // Address-dependent content so a wrong byte lane shows
   assign flash_rd_word = {1'b1, flash_rd_addr} ^ 16'h5A3C;

   always_comb
   begin
      cnt_next = cnt_reg;
      if (flash_start) cnt_next = DLY;
      else if (cnt_reg != 0) cnt_next = cnt_reg - 1;
   end

   always_ff @(posedge ref_clk)
   begin
      cnt_reg    <= rst_n ? cnt_next : 0;
      flash_done <= rst_n && cnt_reg == 1;
   end
endmodule
`default_nettype wire

// ==== sps_pkg.sv ====
// Constants, register map and state type for the self-programming
// flash sequencer. Assumes a 40 MHz CPU clock and an AXI4-Lite master.
package sps_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0]  OFS_CTRL  = 8'h00;
   localparam logic [7:0]  OFS_PTR   = 8'h04;
   localparam logic [7:0]  OFS_DATA  = 8'h08;
   localparam logic [7:0]  OFS_STORE = 8'h0C;
   localparam logic [7:0]  OFS_LOAD  = 8'h10;

   ////////////////////////////////////////////////////////////////////////
   // Store control register fields
   localparam int          BIT_EN    = 0;
   localparam int          CMD_LSB   = 1;
   localparam int          CMD_MSB   = 3;
   localparam int          BIT_RRE   = 4;
   localparam int          BIT_BUSY  = 6;
   localparam int          BIT_IRQE  = 7;
   localparam logic [2:0]  CMD_LOAD  = 3'h0;
   localparam logic [2:0]  CMD_ERASE = 3'h1;
   localparam logic [2:0]  CMD_WRITE = 3'h2;
   localparam logic [2:0]  CMD_LOCK  = 3'h4;

   ////////////////////////////////////////////////////////////////////////
   // Flash geometry and timing
   localparam int          WORD_BITS = 6;
   localparam int          PAGE_BITS = 9;
   localparam int          BUF_WORDS = 64;
   localparam int          LOCK_BITS = 6;
   localparam logic [2:0]  ARM_CYCLES = 3'h4;
   localparam logic [15:0] APP_RESET  = 16'h0000;
   localparam logic [15:0] ERASED_WORD = 16'hFFFF;
   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   typedef enum logic [1:0]
   {
      ST_IDLE  = 2'h0,
      ST_ARMED = 2'h1,
      ST_BUSY  = 2'h3
   } sps_state_e;

endpackage

// ==== sps_seq_properties.sv ====
// Port-level checks on the flash sequencer.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module sps_seq_properties
#(
   parameter logic [15:0] BOOT_RESET = 16'h7E00,
   parameter logic [8:0]  NON_READ_WHILE_WRITE_SECTION_PAGE  = 9'h1C0
)
(
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        rst_n,
   // Write data channel
   input wire logic        wvalid,
   input wire logic        wready,
   // Fuse
   input wire logic        boot_reset_select_fuse,
   input wire logic [15:0] reset_vector,
   // Flash and CPU
   input wire logic        flash_start,
   input wire logic        flash_erase,
   input wire logic [8:0]  flash_page,
   input wire logic        flash_done,
   input wire logic        cpu_halt,
   input wire logic        section_read_block,
   input wire logic        store_irq
);
   logic run_q;
   logic wr_q;

   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   // Op in flight from cycle after start until done
   always_ff @(posedge ref_clk)
   begin
      wr_q  <= wvalid && wready;
      run_q <= rst_n && (flash_start || (run_q && !flash_done));
   end

   sequence s_op_end;
      run_q && flash_done;
   endsequence

   // Busy may only drop around a register write
   sequence s_no_write;
      section_read_block && !(wvalid && wready) && !wr_q;
   endsequence

   reset_app_a: assert property (
      boot_reset_select_fuse [*5] |-> reset_vector == 16'h0000)
      else $error("reset vector not application start");
   reset_boot_a: assert property (
      !boot_reset_select_fuse [*5] |-> reset_vector == BOOT_RESET)
      else $error("reset vector not boot start");
   start_pulse_a: assert property (
      flash_start |=> !flash_start)
      else $error("start longer than one cycle");
   page_latched_a: assert property (
      run_q |-> $stable(flash_page) && $stable(flash_erase))
      else $error("page changed during operation");
   busy_set_a: assert property (
      flash_start |=> section_read_block [*3])
      else $error("busy flag not set by operation");
   busy_hold_a: assert property (
      s_no_write |=> section_read_block)
      else $error("busy flag dropped without write");
   halt_non_read_while_write_section_a: assert property (
      run_q && !flash_done && flash_page >= NON_READ_WHILE_WRITE_SECTION_PAGE |-> cpu_halt)
      else $error("cpu not halted for protected page");
   halt_only_a: assert property (
      cpu_halt |-> ##[0:1] (section_read_block && flash_page >= NON_READ_WHILE_WRITE_SECTION_PAGE))
      else $error("cpu halted outside protected op");
   halt_release_a: assert property (
      s_op_end |=> !cpu_halt)
      else $error("cpu still halted after done");
   irq_quiet_a: assert property (
      run_q |-> !store_irq)
      else $error("interrupt while operation runs");
endmodule

bind sps_sequencer sps_seq_properties #(
   .BOOT_RESET(BOOT_RESET), .NON_READ_WHILE_WRITE_SECTION_PAGE(NON_READ_WHILE_WRITE_SECTION_PAGE)) u_sps_seq_properties (
   .ref_clk, .rst_n, .wvalid, .wready, .boot_reset_select_fuse,
   .reset_vector, .flash_start, .flash_erase, .flash_page, .flash_done,
   .cpu_halt, .section_read_block, .store_irq);
`default_nettype wire

// ==== sps_sequencer.sv ====
// Self-programming flash sequencer with AXI4-Lite register access.
// Assumes a flash macro on the same clock that starts on flash_start,
// reads the page buffer through buf_rd_idx and pulses flash_done.
`timescale 1ns/10ps
`default_nettype none
module sps_sequencer
#(
   parameter logic [15:0]                  BOOT_RESET = 16'h7E00,
   parameter logic [sps_pkg::PAGE_BITS-1:0] NON_READ_WHILE_WRITE_SECTION_PAGE = 9'h1C0
)
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // AXI4-Lite write
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [7:0]  awaddr,
   input  wire logic        wvalid,
   output logic             wready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   output logic             bvalid,
   input  wire logic        bready,
   output logic [1:0]       bresp,
   // AXI4-Lite read
   input  wire logic        arvalid,
   output logic             arready,
   input  wire logic [7:0]  araddr,
   output logic             rvalid,
   input  wire logic        rready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   // Fuse and reset vector
   input  wire logic        boot_reset_select_fuse,
   output logic [15:0]      reset_vector,
   // Flash macro
   output logic             flash_start,
   output logic             flash_erase,
   output logic [8:0]       flash_page,
   input  wire logic        flash_done,
   input  wire logic [5:0]  buf_rd_idx,
   output logic [15:0]      buf_rd_data,
   output logic [14:0]      flash_rd_addr,
   input  wire logic [15:0] flash_rd_word,
   // Lock bits
   output logic             lock_set,
   output logic [5:0]       lock_bits,
   // CPU side
   input  wire logic        eeprom_write,
   output logic             cpu_halt,
   output logic             section_read_block,
   output logic             store_irq
);

   ////////////////////////////////////////////////////////////////////////
   // Byte-lane merge for register writes
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (st[i])
            r[i*8 +: 8] = nw[i*8 +: 8];
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // State
   sps_pkg::sps_state_e  state_reg, state_next;
   logic [2:0]           cnt_reg, cnt_next;
   logic [2:0]           cmd_reg, cmd_next;
   logic                 irqe_reg, irqe_next;
   logic                 busy_reg, busy_next;
   logic [15:0]          ptr_reg, ptr_next;
   logic [15:0]          data_reg, data_next;
   logic [8:0]           page_reg, page_next;
   logic                 non_read_while_write_section_reg, non_read_while_write_section_next;
   logic                 wr_reg, wr_next;
   logic                 start_reg, start_next;
   logic                 lset_reg, lset_next;
   logic [5:0]           lbits_reg, lbits_next;
   logic [63:0]          valid_reg, valid_next;
   logic [15:0]          brd_reg, brd_next;
   logic [15:0]          buf_mem [sps_pkg::BUF_WORDS];
   logic                 buf_we;
   logic                 fuse_s1_reg, fuse_s2_reg;
   logic [15:0]          vec_reg;
   logic                 awv_reg, awv_next;
   logic [7:0]           awa_reg, awa_next;
   logic                 wv_reg, wv_next;
   logic [31:0]          wd_reg, wd_next;
   logic [3:0]           ws_reg, ws_next;
   logic                 bv_reg, bv_next;
   logic [1:0]           br_reg, br_next;
   logic                 rv_reg, rv_next;
   logic [31:0]          rd_reg, rd_next;
   logic [1:0]           rr_reg, rr_next;
   logic [31:0]          wm;
   logic [31:0]          ptr_m;
   logic [31:0]          data_m;
   logic [7:0]           ctrl_rd;

   assign awready = !awv_reg;
   assign wready  = !wv_reg;
   assign arready = !rv_reg;
   assign bvalid  = bv_reg;
   assign bresp   = br_reg;
   assign rvalid  = rv_reg;
   assign rdata   = rd_reg;
   assign rresp   = rr_reg;
   assign flash_start  = start_reg;
   assign flash_erase  = !wr_reg;
   assign flash_page   = page_reg;
   assign buf_rd_data  = brd_reg;
   assign flash_rd_addr = ptr_reg[15:1];
   assign lock_set     = lset_reg;
   assign lock_bits    = lbits_reg;
   assign reset_vector = vec_reg;
   assign cpu_halt = (state_reg == sps_pkg::ST_BUSY) && non_read_while_write_section_reg;
   assign section_read_block = busy_reg;
   assign store_irq = irqe_reg && (state_reg == sps_pkg::ST_IDLE);

   always_comb
   begin
      ctrl_rd = 8'h00;
      ctrl_rd[sps_pkg::BIT_EN] = (state_reg != sps_pkg::ST_IDLE);
      ctrl_rd[sps_pkg::CMD_MSB:sps_pkg::CMD_LSB] =
         (state_reg == sps_pkg::ST_IDLE) ? 3'h0 : cmd_reg;
      ctrl_rd[sps_pkg::BIT_BUSY] = busy_reg;
      ctrl_rd[sps_pkg::BIT_IRQE] = irqe_reg;
   end

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb
   begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      cmd_next   = cmd_reg;
      irqe_next  = irqe_reg;
      busy_next  = busy_reg;
      ptr_next   = ptr_reg;
      data_next  = data_reg;
      page_next  = page_reg;
      non_read_while_write_section_next  = non_read_while_write_section_reg;
      wr_next    = wr_reg;
      start_next = 1'b0;
      lset_next  = 1'b0;
      lbits_next = lbits_reg;
      valid_next = valid_reg;
      buf_we     = 1'b0;
      awv_next   = awv_reg;
      awa_next   = awa_reg;
      wv_next    = wv_reg;
      wd_next    = wd_reg;
      ws_next    = ws_reg;
      bv_next    = bv_reg && !bready;
      br_next    = br_reg;
      rv_next    = rv_reg && !rready;
      rd_next    = rd_reg;
      rr_next    = rr_reg;
      wm = merge(32'h0000_0000, wd_reg, ws_reg);
      ptr_m  = merge({16'h0000, ptr_reg}, wd_reg, ws_reg);
      data_m = merge({16'h0000, data_reg}, wd_reg, ws_reg);
      brd_next = valid_reg[buf_rd_idx] ? buf_mem[buf_rd_idx]
                                       : sps_pkg::ERASED_WORD;

      // Unused arming lapses after the window
      if (state_reg == sps_pkg::ST_ARMED)
      begin
         cnt_next = cnt_reg - 3'h1;
         if (cnt_reg == 3'h1)
            state_next = sps_pkg::ST_IDLE;
      end
      // Operation end; page write empties the buffer
      if (state_reg == sps_pkg::ST_BUSY && flash_done)
      begin
         state_next = sps_pkg::ST_IDLE;
         if (wr_reg)
            valid_next = '0;
      end

      if (!awv_reg && awvalid)
      begin
         awv_next = 1'b1;
         awa_next = awaddr;
      end
      if (!wv_reg && wvalid)
      begin
         wv_next = 1'b1;
         wd_next = wdata;
         ws_next = wstrb;
      end

      if (awv_reg && wv_reg && !bv_reg)
      begin
         awv_next = 1'b0;
         wv_next  = 1'b0;
         bv_next  = 1'b1;
         br_next  = sps_pkg::RESP_OKAY;
         case (awa_reg)
            sps_pkg::OFS_CTRL:
               if (ws_reg[0])
               begin
                  irqe_next = wm[sps_pkg::BIT_IRQE];
                  if (wm[sps_pkg::BIT_RRE] &&
                      state_reg != sps_pkg::ST_BUSY)
                  begin
                     busy_next  = 1'b0;
                     valid_next = '0;
                  end
                  else if (wm[sps_pkg::BIT_EN] &&
                           state_reg == sps_pkg::ST_IDLE)
                  begin
                     state_next = sps_pkg::ST_ARMED;
                     cnt_next   = sps_pkg::ARM_CYCLES;
                     cmd_next   = wm[sps_pkg::CMD_MSB:sps_pkg::CMD_LSB];
                  end
               end
            sps_pkg::OFS_PTR:
               ptr_next = ptr_m[15:0];
            sps_pkg::OFS_DATA:
               data_next = data_m[15:0];
            sps_pkg::OFS_STORE:
               if (state_reg == sps_pkg::ST_ARMED)
               begin
                  state_next = sps_pkg::ST_IDLE;
                  case (cmd_reg)
                     sps_pkg::CMD_LOAD:
                        buf_we = 1'b1;
                     sps_pkg::CMD_ERASE,
                     sps_pkg::CMD_WRITE:
                     begin
                        state_next = sps_pkg::ST_BUSY;
                        page_next  = ptr_reg[15:7];
                        non_read_while_write_section_next  = (ptr_reg[15:7] >= NON_READ_WHILE_WRITE_SECTION_PAGE);
                        wr_next    = (cmd_reg == sps_pkg::CMD_WRITE);
                        start_next = 1'b1;
                        busy_next  = 1'b1;
                     end
                     sps_pkg::CMD_LOCK:
                     begin
                        lset_next  = 1'b1;
                        lbits_next = data_reg[5:0];
                     end
                     default:
                        state_next = sps_pkg::ST_IDLE;
                  endcase
               end
            sps_pkg::OFS_LOAD:
               br_next = sps_pkg::RESP_OKAY;
            default:
               br_next = sps_pkg::RESP_SLVERR;
         endcase
      end

      if (buf_we)
         valid_next[ptr_reg[6:1]] = 1'b1;
      if (eeprom_write)
         valid_next = '0;

      if (arvalid && !rv_reg)
      begin
         rv_next = 1'b1;
         rr_next = sps_pkg::RESP_OKAY;
         case (araddr)
            sps_pkg::OFS_CTRL:  rd_next = {24'h000000, ctrl_rd};
            sps_pkg::OFS_PTR:   rd_next = {16'h0000, ptr_reg};
            sps_pkg::OFS_DATA:  rd_next = {16'h0000, data_reg};
            sps_pkg::OFS_STORE: rd_next = 32'h0000_0000;
            sps_pkg::OFS_LOAD:
               rd_next = {24'h000000, ptr_reg[0] ? flash_rd_word[15:8]
                                                 : flash_rd_word[7:0]};
            default:
            begin
               rd_next = 32'h0000_0000;
               rr_next = sps_pkg::RESP_SLVERR;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge ref_clk)
   begin
      if (buf_we)
         buf_mem[ptr_reg[6:1]] <= data_reg;
      if (!rst_n)
      begin
         state_reg <= sps_pkg::ST_IDLE;
         cnt_reg   <= 3'h0;
         cmd_reg   <= 3'h0;
         irqe_reg  <= 1'b0;
         busy_reg  <= 1'b0;
         ptr_reg   <= 16'h0000;
         data_reg  <= 16'h0000;
         page_reg  <= 9'h000;
         non_read_while_write_section_reg  <= 1'b0;
         wr_reg    <= 1'b0;
         start_reg <= 1'b0;
         lset_reg  <= 1'b0;
         lbits_reg <= 6'h3F;
         valid_reg <= '0;
         brd_reg   <= sps_pkg::ERASED_WORD;
         awv_reg   <= 1'b0;
         awa_reg   <= 8'h00;
         wv_reg    <= 1'b0;
         wd_reg    <= 32'h0000_0000;
         ws_reg    <= 4'h0;
         bv_reg    <= 1'b0;
         br_reg    <= 2'h0;
         rv_reg    <= 1'b0;
         rd_reg    <= 32'h0000_0000;
         rr_reg    <= 2'h0;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         cmd_reg   <= cmd_next;
         irqe_reg  <= irqe_next;
         busy_reg  <= busy_next;
         ptr_reg   <= ptr_next;
         data_reg  <= data_next;
         page_reg  <= page_next;
         non_read_while_write_section_reg  <= non_read_while_write_section_next;
         wr_reg    <= wr_next;
         start_reg <= start_next;
         lset_reg  <= lset_next;
         lbits_reg <= lbits_next;
         valid_reg <= valid_next;
         brd_reg   <= brd_next;
         awv_reg   <= awv_next;
         awa_reg   <= awa_next;
         wv_reg    <= wv_next;
         wd_reg    <= wd_next;
         ws_reg    <= ws_next;
         bv_reg    <= bv_next;
         br_reg    <= br_next;
         rv_reg    <= rv_next;
         rd_reg    <= rd_next;
         rr_reg    <= rr_next;
      end
   end

   // Fuse is a pin: synchronised, read only, no path from software
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         fuse_s1_reg <= 1'b1;
         fuse_s2_reg <= 1'b1;
         vec_reg     <= sps_pkg::APP_RESET;
      end
      else
      begin
         fuse_s1_reg <= boot_reset_select_fuse;
         fuse_s2_reg <= fuse_s1_reg;
         vec_reg <= fuse_s2_reg ? sps_pkg::APP_RESET : BOOT_RESET;
      end
   end

endmodule
`default_nettype wire

// ==== sps_sequencer_tb_top.sv ====
// Self-checking bench for the flash sequencer.
// Assumes the flash model and the bound property checker.
`timescale 1ns/10ps
`default_nettype none
module sps_sequencer_tb_top;
   localparam logic [15:0] BOOT = 16'h7E00;
   localparam logic [8:0]  NON_READ_WHILE_WRITE_SECTION = 9'h1C0;
   localparam logic [8:0]  PG   = 9'h010;
   localparam logic [7:0]  CTL  = sps_pkg::OFS_CTRL;
   localparam logic [7:0]  PTR  = sps_pkg::OFS_PTR;
   logic        ref_clk, rst_n, awvalid, awready, wvalid, wready;
   logic        bvalid, bready, arvalid, arready, rvalid, rready;
   logic        fuse, start, erase, done, lock_set, ee_wr, halt, blk, irq;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rsp;
   logic [15:0] rvec, bdata, fword, fw;
   logic [8:0]  page;
   logic [5:0]  idx, lbits;
   logic [14:0] faddr;
   int          n_fail, check_count;
   int          n_lock;

   sps_sequencer #(.BOOT_RESET(BOOT), .NON_READ_WHILE_WRITE_SECTION_PAGE(NON_READ_WHILE_WRITE_SECTION)) u_sps_sequencer (
      .ref_clk, .rst_n, .awvalid, .awready, .awaddr, .wvalid, .wready,
      .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
      .araddr, .rvalid, .rready, .rdata, .rresp,
      .boot_reset_select_fuse(fuse), .reset_vector(rvec),
      .flash_start(start), .flash_erase(erase), .flash_page(page),
      .flash_done(done), .buf_rd_idx(idx), .buf_rd_data(bdata),
      .flash_rd_addr(faddr), .flash_rd_word(fword), .lock_set(lock_set),
      .lock_bits(lbits), .eeprom_write(ee_wr), .cpu_halt(halt),
      .section_read_block(blk), .store_irq(irq));

   sps_flash_model #(.DLY(12)) u_sps_flash_model (.ref_clk, .rst_n,
      .flash_start(start), .flash_done(done), .flash_rd_addr(faddr),
      .flash_rd_word(fword));

   // Lock pulse lasts one cycle, so count it as it passes
   always @(posedge ref_clk)
      if (lock_set)
         n_lock <= n_lock + 1;

   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic end_of_test();
      if (n_fail == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                      input string what);
      check_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er = sps_pkg::RESP_OKAY);
      @(posedge ref_clk);
      awvalid <= 1'b1;
      awaddr  <= a;
      wvalid  <= 1'b1;
      wdata   <= d;
      bready  <= 1'b1;
      forever
      begin
         @(posedge ref_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      rsp = bresp;
      bready <= 1'b0;
      chk({30'h0, rsp}, {30'h0, er}, "write response");
   endtask

   task automatic rdr(input logic [7:0] a);
      @(posedge ref_clk);
      arvalid <= 1'b1;
      araddr  <= a;
      rready  <= 1'b1;
      forever
      begin
         @(posedge ref_clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rd = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask

   // Arm then store, inside the four-cycle window
   task automatic op(input logic [31:0] c);
      wr(CTL, c);
      wr(sps_pkg::OFS_STORE, 32'h0);
   endtask

   task automatic ldw(input logic [5:0] s, input logic [15:0] d);
      wr(PTR, {16'h0, PG, s, 1'b0});
      wr(sps_pkg::OFS_DATA, {16'h0, d});
      op(32'h01);
   endtask

   task automatic bchk(input logic [5:0] s, input logic [15:0] e);
      idx <= s;
      repeat (2) @(posedge ref_clk);
      chk({16'h0, bdata}, {16'h0, e}, "buffer word");
   endtask

   task automatic stat(input logic [31:0] e);
      rdr(CTL);
      chk(rd & 32'h41, e, "enable and busy");
   endtask

   task automatic wait_done();
      do @(posedge ref_clk); while (done !== 1'b1);
      @(posedge ref_clk);
   endtask

   initial
   begin
      {awvalid, wvalid, bready, arvalid, rready, ee_wr, fuse} = '0;
      {awaddr, araddr, wdata, idx} = '0;
      wstrb = 4'hF;
      rst_n = 1'b0;
      n_fail = 0;
      check_count = 0;
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge ref_clk);
      chk({16'h0, rvec}, {16'h0, BOOT}, "reset vector");
      chk({26'h0, lbits}, 32'h3F, "lock bits");
      stat(32'h0);
      fuse <= 1'b1;
      repeat (6) @(posedge ref_clk);
      chk({16'h0, rvec}, 32'h0, "reset vector");
      ldw(6'h3F, 16'hBEEF);
      ldw(6'h00, 16'h1234);
      bchk(6'h3F, 16'hBEEF);
      bchk(6'h00, 16'h1234);
      bchk(6'h01, 16'hFFFF);
      wr(PTR, {16'h0, PG, 7'h55});
      wr(sps_pkg::OFS_DATA, 32'hDEAD);
      op(32'h83);
      repeat (2) @(posedge ref_clk);
      chk({23'h0, page}, {23'h0, PG}, "erase page");
      chk({31'h0, erase}, 32'h1, "erase flag");
      chk({30'h0, halt, blk}, 32'h1, "halt and block");
      wr(PTR, 32'h0);
      chk({23'h0, page}, {23'h0, PG}, "latched page");
      stat(32'h41);
      chk({31'h0, irq}, 32'h0, "interrupt");
      wait_done();
      stat(32'h40);
      chk({31'h0, irq}, 32'h1, "interrupt");
      wr(PTR, {16'h0, PG, 7'h0});
      op(32'h05);
      repeat (2) @(posedge ref_clk);
      chk({22'h0, erase, page}, {23'h0, PG}, "write page");
      wait_done();
      bchk(6'h3F, 16'hFFFF);
      stat(32'h40);
      wr(CTL, 32'h10);
      stat(32'h0);
      chk({31'h0, blk}, 32'h0, "block");
      for (int i = 0; i < 2; i++)
      begin
         wr(PTR, {16'h0, NON_READ_WHILE_WRITE_SECTION, 7'h0});
         op(i == 0 ? 32'h03 : 32'h05);
         repeat (2) @(posedge ref_clk);
         chk({31'h0, halt}, 32'h1, "cpu halt");
         wait_done();
         chk({31'h0, halt}, 32'h0, "cpu halt");
         wr(CTL, 32'h10);
      end
      wr(CTL, 32'h03);
      repeat (8) @(posedge ref_clk);
      wr(sps_pkg::OFS_STORE, 32'h0);
      repeat (2) @(posedge ref_clk);
      chk({31'h0, blk}, 32'h0, "late store");
      stat(32'h0);
      ldw(6'h02, 16'h1111);
      ee_wr <= 1'b1;
      @(posedge ref_clk);
      ee_wr <= 1'b0;
      bchk(6'h02, 16'hFFFF);
      ldw(6'h03, 16'h2222);
      bchk(6'h03, 16'h2222);
      wr(CTL, 32'h10);
      bchk(6'h03, 16'hFFFF);
      wr(PTR, 32'hABCD);
      wr(sps_pkg::OFS_DATA, 32'h15);
      op(32'h09);
      @(posedge ref_clk);
      chk({26'h0, lbits}, 32'h15, "lock bits");
      chk(n_lock, 32'h1, "lock pulse");
      for (int b = 0; b < 2; b++)
      begin
         wr(PTR, 32'h1234 | b);
         rdr(sps_pkg::OFS_LOAD);
         fw = {1'b1, 15'h091A} ^ 16'h5A3C;
         chk(rd, {24'h0, b ? fw[15:8] : fw[7:0]}, "load byte");
      end
      rdr(8'h20);
      chk({rd[29:0], rsp}, 32'h2, "unmapped read");
      wr(8'h20, 32'h0, sps_pkg::RESP_SLVERR);
      // Reset in mid-run must empty the page buffer
      ldw(6'h04, 16'h3333);
      bchk(6'h04, 16'h3333);
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      bchk(6'h04, 16'hFFFF);
      chk({16'h0, rvec}, 32'h0, "reset vector");
      end_of_test();
   end

   // Whole run needs a few hundred cycles
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      end_of_test();
   end
endmodule
`default_nettype wire
